// ---- pkg/prtc_map.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes APB word addressing: byte address is four times the register index
`ifndef PRTC_MAP_SVH
`define PRTC_MAP_SVH

`define PRTC_IDX_RESET_CTRL     8'h1F
`define PRTC_IDX_LED_CTRL       8'h25
`define PRTC_IDX_COMPLIANCE     8'h27
`define PRTC_IDX_BASIC_MODE     8'h01
`define PRTC_IDX_SELF_TEST_ONE  8'h1B
`define PRTC_ADDR_W             10

`define PRTC_BIT_SW_RESET       15
`define PRTC_BIT_DIG_RESTART    14
`define PRTC_BIT_LED_POL        9
`define PRTC_LED_SEL_HI         6
`define PRTC_LED_SEL_LO         3
`define PRTC_LED_ROUTE_HI       1
`define PRTC_LED_ROUTE_LO       0
`define PRTC_BIT_CT_ENABLE      4
`define PRTC_CT_PAT_HI          3
`define PRTC_CT_PAT_LO          0
`define PRTC_BIT_BIST_CLEAR     15

`define PRTC_LED_CTRL_MASK      16'h027B
`define PRTC_COMPLIANCE_MASK    16'h001F
`define PRTC_LED_SEL_RESET      4'h0
`define PRTC_LED_ROUTE_RESET    2'h0
`define PRTC_CT_RESET           5'h00

`define PRTC_RESET_PULSE_CYC    16

`endif

// ---- pkg/prtc_pkg.sv ----
// Types for the transceiver reset, indicator and compliance control bank
// Offsets and constants live in prtc_map.svh
package prtc_pkg;

    typedef enum logic [3:0] {
        SRC_LINK_GOOD      = 4'h0,
        SRC_ACTIVITY       = 4'h1,
        SRC_TX_ACTIVITY    = 4'h2,
        SRC_RX_ACTIVITY    = 4'h3,
        SRC_COLLISION      = 4'h4,
        SRC_SPEED_100      = 4'h5,
        SRC_SPEED_10       = 4'h6,
        SRC_FULL_DUPLEX    = 4'h7,
        SRC_LINK_BLINK     = 4'h8,
        SRC_STRETCH        = 4'h9,
        SRC_LINK_100_FD    = 4'hA,
        SRC_LOW_POWER_IDLE = 4'hB,
        SRC_MII_ERROR      = 4'hC,
        SRC_LINK_LOST      = 4'hD,
        SRC_PRBS_ERROR     = 4'hE,
        SRC_RESERVED       = 4'hF
    } prtc_led_src_t;

    typedef struct packed {
        logic link_good;
        logic tx_activity;
        logic rx_activity;
        logic collision;
        logic speed_100;
        logic speed_10;
        logic full_duplex;
        logic blink;
        logic stretch;
        logic low_power_idle;
        logic mii_error;
        logic prbs_error;
    } prtc_status_t;

    typedef struct packed {
        logic       enable;
        logic [3:0] pattern;
    } prtc_test_t;

endpackage

// ---- design/prtc_top.sv ----
// Reset control, multi-function indicator and compliance test control registers
// Assumes an APB master on CLK and status inputs synchronous to CLK
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "prtc_map.svh"

// What this block does
// - Writing one to the software reset bit resets the whole transceiver like the reset pin, then self-clears.
// - Writing one to the digital restart bit resets digital logic but keeps registers, then self-clears.
// - The indicator polarity bit resets from the strap on the strap LED pin, pull-up giving 0, and is writable.
// - A four-bit selector reset to zero picks link good, activity, transmit or receive activity.
// - Codes 0101, 0110 and 0111 select 100 Mbit speed, 10 Mbit speed and full duplex.
// - Codes 1000 to 1100 select blink, stretch, 100 Mbit full-duplex link, idle and error; 1111 is reserved.
// - Code 1101 lights the indicator when the link drops until software reads the basic mode register.
// - Code 1110 lights the indicator on one checker error until the self-test status is cleared.
// - A routing field sends the indicator to the strap LED pin at 00 and the first LED pin at 11.
// - The compliance enable bit turns 10 Mbit test patterns on, reset value off.
// - With patterns enabled the low four compliance bits pick the pattern.
// - Writing one to bit 15 of the self-test status register latches and clears the error count.
module prtc_top
    import prtc_pkg::*;
#(
    parameter int RESET_PULSE_CYC = `PRTC_RESET_PULSE_CYC
) (
    input  wire logic                    CLK,
    input  wire logic                    RST,
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [`PRTC_ADDR_W-1:0] PADDR,
    input  wire logic [31:0]             PWDATA,
    input  wire logic [3:0]              PSTRB,
    output logic      [31:0]             PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    input  wire logic                    STRAP_LED_IN,
    input  wire prtc_pkg::prtc_status_t  STATUS,
    input  wire logic                    BASIC_MODE_READ,
    output logic                         STRAP_LED_OUT,
    output logic                         STRAP_LED_OE,
    output logic                         FIRST_INDICATOR_PIN,
    output logic                         SOFT_RESET,
    output logic                         DIGITAL_RESTART,
    output logic                         BIST_COUNT_CLEAR,
    output prtc_pkg::prtc_test_t         TEST_CTRL
);
    import prtc_pkg::*;

    // The pulse counters are eight bits wide
    if (RESET_PULSE_CYC < 1 || RESET_PULSE_CYC > 255) begin : g_bad_pulse
        $error("RESET_PULSE_CYC must lie in 1..255");
    end

    // Register file
    logic        led_pol_r;
    logic [3:0]  led_sel_r;
    logic [1:0]  led_route_r;
    logic [4:0]  ct_r;
    logic [7:0]  sw_cnt_r;
    logic [7:0]  dr_cnt_r;
    logic        strap_taken_r;
    logic        link_prev_r;
    logic        link_lost_r;
    logic        prbs_hold_r;
    logic        led_on_r;
    logic        ready_r;
    logic [31:0] rdata_r;
    logic        slverr_r;

    function automatic logic hit(input logic [`PRTC_ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[1:0] == 2'h0) && (a[`PRTC_ADDR_W-1:2] == idx);
    endfunction

    wire access   = PSEL && PENABLE && !ready_r;
    wire wr       = access && PWRITE;
    wire rd       = access && !PWRITE;
    wire hi_lane  = PSTRB[1];
    wire lo_lane  = PSTRB[0];
    wire hit_rst  = hit(PADDR, `PRTC_IDX_RESET_CTRL);
    wire hit_led  = hit(PADDR, `PRTC_IDX_LED_CTRL);
    wire hit_ct   = hit(PADDR, `PRTC_IDX_COMPLIANCE);
    wire hit_bist = hit(PADDR, `PRTC_IDX_SELF_TEST_ONE);
    wire mapped   = hit_rst || hit_led || hit_ct || hit_bist;

    // Self-test status lives elsewhere; only the clear action is taken here
    wire bist_clear = wr && hit_bist && hi_lane && PWDATA[`PRTC_BIT_BIST_CLEAR];
    wire sw_go      = wr && hit_rst && hi_lane && PWDATA[`PRTC_BIT_SW_RESET];
    wire dr_go      = wr && hit_rst && hi_lane && PWDATA[`PRTC_BIT_DIG_RESTART];
    wire sw_busy    = sw_cnt_r != 8'h00;
    wire dr_busy    = dr_cnt_r != 8'h00;
    // Software reset behaves as RST for the register bank
    wire bank_rst   = RST || sw_busy;
    wire [7:0] pulse_len = 8'(RESET_PULSE_CYC);

    wire [15:0] rst_view = {sw_busy, dr_busy, 14'h0000};
    wire [15:0] led_view = {6'h00, led_pol_r, 2'h0, led_sel_r, 1'b0, led_route_r};
    wire [15:0] ct_view  = {11'h000, ct_r};
    wire [15:0] rd_mux   = hit_rst ? rst_view :
                           hit_led ? led_view :
                           hit_ct  ? ct_view  : 16'h0000;

    // Digital restart clears the sticky indicator state but not the registers
    wire dig_clr   = bank_rst || dr_busy;
    wire link_drop = link_prev_r && !STATUS.link_good;

    wire src_sel;
    prtc_led_src_t src;
    assign src = prtc_led_src_t'(led_sel_r);
    logic src_val;
    always_comb begin
        unique case (src)
            SRC_LINK_GOOD:      src_val = STATUS.link_good;
            SRC_ACTIVITY:       src_val = STATUS.tx_activity || STATUS.rx_activity;
            SRC_TX_ACTIVITY:    src_val = STATUS.tx_activity;
            SRC_RX_ACTIVITY:    src_val = STATUS.rx_activity;
            SRC_COLLISION:      src_val = STATUS.collision;
            SRC_SPEED_100:      src_val = STATUS.speed_100;
            SRC_SPEED_10:       src_val = STATUS.speed_10;
            SRC_FULL_DUPLEX:    src_val = STATUS.full_duplex;
            SRC_LINK_BLINK:     src_val = STATUS.link_good && !STATUS.blink;
            SRC_STRETCH:        src_val = STATUS.stretch;
            SRC_LINK_100_FD:    src_val = STATUS.link_good && STATUS.speed_100
                                          && STATUS.full_duplex;
            SRC_LOW_POWER_IDLE: src_val = STATUS.low_power_idle;
            SRC_MII_ERROR:      src_val = STATUS.mii_error;
            SRC_LINK_LOST:      src_val = link_lost_r;
            SRC_PRBS_ERROR:     src_val = prbs_hold_r;
            SRC_RESERVED:       src_val = 1'b0;
        endcase
    end
    assign src_sel = src_val;

    // Active high when polarity bit is set, else the pin is driven low for on
    wire led_level = led_pol_r ? led_on_r : !led_on_r;
    wire to_strap  = led_route_r == 2'b00;
    wire to_first  = led_route_r == 2'b11;

    always_ff @(posedge CLK) begin
        if (RST) begin
            sw_cnt_r <= 8'h00;
        end else if (sw_go) begin
            sw_cnt_r <= pulse_len;
        end else if (sw_busy) begin
            sw_cnt_r <= sw_cnt_r - 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (bank_rst) begin
            dr_cnt_r <= 8'h00;
        end else if (dr_go) begin
            dr_cnt_r <= pulse_len;
        end else if (dr_busy) begin
            dr_cnt_r <= dr_cnt_r - 8'h01;
        end
    end

    // Strap is caught on the first clock after reset ends, never under reset
    always_ff @(posedge CLK) begin
        if (bank_rst) begin
            strap_taken_r <= 1'b0;
            led_pol_r     <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            led_pol_r     <= !STRAP_LED_IN;
        end else if (wr && hit_led && hi_lane) begin
            led_pol_r     <= PWDATA[`PRTC_BIT_LED_POL];
        end
    end

    always_ff @(posedge CLK) begin
        if (bank_rst) begin
            led_sel_r   <= `PRTC_LED_SEL_RESET;
            led_route_r <= `PRTC_LED_ROUTE_RESET;
        end else if (wr && hit_led && lo_lane) begin
            led_sel_r   <= PWDATA[`PRTC_LED_SEL_HI:`PRTC_LED_SEL_LO];
            led_route_r <= PWDATA[`PRTC_LED_ROUTE_HI:`PRTC_LED_ROUTE_LO];
        end
    end

    always_ff @(posedge CLK) begin
        if (bank_rst) begin
            ct_r <= `PRTC_CT_RESET;
        end else if (wr && hit_ct && lo_lane) begin
            ct_r <= PWDATA[4:0];
        end
    end

    // Sticky sources: a new event in the clearing cycle wins over the clear
    always_ff @(posedge CLK) begin
        if (dig_clr) begin
            link_prev_r <= 1'b0;
            link_lost_r <= 1'b0;
            prbs_hold_r <= 1'b0;
            led_on_r    <= 1'b0;
        end else begin
            link_prev_r <= STATUS.link_good;
            link_lost_r <= link_drop || (link_lost_r && !BASIC_MODE_READ);
            prbs_hold_r <= STATUS.prbs_error || (prbs_hold_r && !bist_clear);
            led_on_r    <= src_sel;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            STRAP_LED_OUT       <= 1'b0;
            STRAP_LED_OE        <= 1'b0;
            FIRST_INDICATOR_PIN <= 1'b0;
            SOFT_RESET          <= 1'b0;
            DIGITAL_RESTART     <= 1'b0;
            BIST_COUNT_CLEAR    <= 1'b0;
            TEST_CTRL           <= '0;
        end else begin
            STRAP_LED_OUT       <= to_strap ? led_level : 1'b0;
            STRAP_LED_OE        <= to_strap && strap_taken_r;
            FIRST_INDICATOR_PIN <= to_first ? led_level : !led_pol_r;
            SOFT_RESET          <= sw_busy || sw_go;
            DIGITAL_RESTART     <= dr_busy || dr_go;
            BIST_COUNT_CLEAR    <= bist_clear;
            TEST_CTRL           <= '{enable: ct_r[`PRTC_BIT_CT_ENABLE],
                                     pattern: ct_r[`PRTC_CT_PAT_HI:`PRTC_CT_PAT_LO]};
        end
    end

    // One wait state: the answer comes on the second access cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            ready_r  <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else begin
            ready_r  <= access;
            slverr_r <= access && !mapped;
            rdata_r  <= rd ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    assign PREADY  = ready_r;
    assign PRDATA  = rdata_r;
    assign PSLVERR = slverr_r;

    logic unused_bits;
    assign unused_bits = ^{PSTRB[3:2], PWDATA[31:16]};

endmodule
`default_nettype wire

// ---- test/prtc_properties.sv ----
// Concurrent checks on the control bank's APB answers and control outputs
// Assumes binding onto prtc_top, one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module prtc_properties
    import prtc_pkg::*;
#(
    parameter int RESET_PULSE_CYC = 16
) (
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [9:0]           PADDR,
    input  wire logic [31:0]          PWDATA,
    input  wire logic [3:0]           PSTRB,
    input  wire logic [31:0]          PRDATA,
    input  wire logic                 PREADY,
    input  wire logic                 PSLVERR,
    input  wire logic                 SOFT_RESET,
    input  wire logic                 DIGITAL_RESTART,
    input  wire logic                 BIST_COUNT_CLEAR,
    input  wire prtc_pkg::prtc_test_t TEST_CTRL
);
    logic [7:0] sr_cnt;
    logic [7:0] dr_cnt;
    wire        acc    = PSEL && PENABLE && !PREADY;
    wire        wr_hi  = acc && PWRITE && PSTRB[1];
    wire        mapped = PADDR == 10'h06C || PADDR == 10'h07C || PADDR == 10'h094
                         || PADDR == 10'h09C;

    // Counts the high cycles of each reset strobe so its length can be judged at the fall
    always_ff @(posedge CLK) begin
        sr_cnt <= (RST || !SOFT_RESET) ? 8'h00 : sr_cnt + 8'h01;
        dr_cnt <= (RST || !DIGITAL_RESTART) ? 8'h00 : dr_cnt + 8'h01;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_ready_wait: assert property (acc |=> PREADY) else $error("no answer to access");
    a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready held too long");
    a_ready_cause: assert property (PREADY |-> $past(acc)) else $error("ready without access");
    a_err_map: assert property (acc |=> PSLVERR == !$past(mapped)) else $error("bad error flag");
    a_err_zero: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("error with data");
    a_upper_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0)
        else $error("upper half not zero");
    a_soft_start: assert property (wr_hi && PADDR == 10'h07C && PWDATA[15]
        |=> SOFT_RESET) else $error("soft reset not started");
    a_soft_len: assert property ($fell(SOFT_RESET) |-> sr_cnt == RESET_PULSE_CYC + 1)
        else $error("soft reset length wrong");
    a_dig_start: assert property (wr_hi && PADDR == 10'h07C && PWDATA[14]
        |=> DIGITAL_RESTART) else $error("restart not started");
    a_dig_len: assert property ($fell(DIGITAL_RESTART) |-> dr_cnt == RESET_PULSE_CYC + 1)
        else $error("restart length wrong");
    a_bist_pulse: assert property (wr_hi && PADDR == 10'h06C && PWDATA[15]
        |=> BIST_COUNT_CLEAR ##1 !BIST_COUNT_CLEAR) else $error("count clear pulse wrong");
    // The register takes the write at the access edge and the output follows one edge later
    a_test_ctrl: assert property (acc && PWRITE && PSTRB[0] && PADDR == 10'h09C
        |-> ##2 TEST_CTRL == $past(PWDATA[4:0], 2)) else $error("test control not loaded");

    c_soft: cover property (wr_hi && PADDR == 10'h07C);
    c_err: cover property (PSLVERR);
    c_restart: cover property ($fell(DIGITAL_RESTART));
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the reset, indicator and compliance control bank
// Assumes prtc_top with a short reset strobe, driven here as APB master
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import prtc_pkg::*;
    logic         clk, rst, psel, penable, pwrite, strap, bm_read, e;
    logic [9:0]   paddr;
    logic [31:0]  pwdata, prdata, r;
    logic [3:0]   pstrb;
    logic         pready, pslverr, led_out, led_oe, pin, sw_rst, dig_rst, bist_clr;
    prtc_status_t status;
    prtc_test_t   test_ctrl;
    int           failures, checked;
    // Rows: selector code, status levels, expected indicator (active high, first pin)
    localparam logic [16:0] ROWS [20] = '{
        {4'h0, 12'h800, 1'b1}, {4'h0, 12'h7FE, 1'b0}, {4'h1, 12'h200, 1'b1},
        {4'h2, 12'h400, 1'b1}, {4'h2, 12'h200, 1'b0}, {4'h3, 12'h200, 1'b1},
        {4'h4, 12'h100, 1'b1}, {4'h4, 12'h400, 1'b0}, {4'h5, 12'h080, 1'b1},
        {4'h6, 12'h040, 1'b1}, {4'h6, 12'h080, 1'b0}, {4'h7, 12'h020, 1'b1},
        {4'h8, 12'h810, 1'b0}, {4'h8, 12'h800, 1'b1}, {4'h9, 12'h008, 1'b1},
        {4'hA, 12'h8A0, 1'b1}, {4'hA, 12'h820, 1'b0}, {4'hB, 12'h004, 1'b1},
        {4'hC, 12'h002, 1'b1}, {4'hF, 12'hFFE, 1'b0}};

    prtc_top #(.RESET_PULSE_CYC(2)) dut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .STRAP_LED_IN(strap), .STATUS(status), .BASIC_MODE_READ(bm_read),
        .STRAP_LED_OUT(led_out), .STRAP_LED_OE(led_oe), .FIRST_INDICATOR_PIN(pin),
        .SOFT_RESET(sw_rst), .DIGITAL_RESTART(dig_rst), .BIST_COUNT_CLEAR(bist_clr),
        .TEST_CTRL(test_ctrl));

    task automatic end_sim;
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Holds the request until ready is seen high at an edge; a hung slave ends the run
    task automatic apb(input logic w, input logic [9:0] a, input logic [15:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        apb(1'b1, a, d, 4'h3);
        chk(32'(e), 32'h0);
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000, 4'h3);
        chk(r, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bm_pulse;
        bm_read <= 1'b1;
        @(posedge clk);
        bm_read <= 1'b0;
        cyc(3);
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, bm_read} = 4'h0;
        paddr = 10'h000;
        pwdata = 32'h0;
        pstrb = 4'h3;
        strap = 1'b1;
        status = 12'h000;
        failures = 0;
        checked = 0;
        cyc(16);
        rst <= 1'b0;
        rd(10'h07C, 32'h0);
        rd(10'h094, 32'h0);
        rd(10'h09C, 32'h0);
        apb(1'b0, 10'h004, 16'h0000, 4'h3);
        chk(32'(e), 32'h1);
        chk(r, 32'h0);
        for (int i = 0; i < 20; i++) begin
            status <= ROWS[i][12:1];
            wr(10'h094, {9'h004, ROWS[i][16:13], 3'h3});
            cyc(3);
            chk(32'(pin), 32'(ROWS[i][0]));
        end
        status <= 12'h800;
        wr(10'h094, 16'h0003);
        cyc(3);
        chk(32'(pin), 32'h0);
        wr(10'h094, 16'h0200);
        cyc(3);
        chk({30'h0, led_oe, led_out}, 32'h3);
        chk(32'(pin), 32'h0);
        wr(10'h094, 16'h0201);
        cyc(3);
        chk(32'(led_oe), 32'h0);
        wr(10'h094, 16'h026B);
        bm_pulse();
        chk(32'(pin), 32'h0);
        status <= 12'h000;
        cyc(3);
        status <= 12'h800;
        cyc(3);
        chk(32'(pin), 32'h1);
        bm_pulse();
        chk(32'(pin), 32'h0);
        status <= 12'h000;
        wr(10'h094, 16'h0273);
        cyc(3);
        chk(32'(pin), 32'h0);
        status <= 12'h001;
        cyc(1);
        status <= 12'h000;
        cyc(3);
        chk(32'(pin), 32'h1);
        wr(10'h06C, 16'h8000);
        chk(32'(bist_clr), 32'h1);
        cyc(3);
        chk(32'(pin), 32'h0);
        rd(10'h06C, 32'h0);
        wr(10'h094, 16'hFFFF);
        rd(10'h094, 32'h027B);
        apb(1'b1, 10'h094, 16'h0000, 4'h1);
        rd(10'h094, 32'h0200);
        wr(10'h09C, 16'hFFFF);
        rd(10'h09C, 32'h001F);
        // The control output follows the register one edge after the write lands
        wr(10'h09C, 16'h0009);
        cyc(1);
        chk(32'(test_ctrl), 32'h09);
        wr(10'h09C, 16'h0019);
        cyc(1);
        chk(32'(test_ctrl), 32'h19);
        wr(10'h07C, 16'h3FFF);
        rd(10'h07C, 32'h0);
        // Link dropped earlier and was never acknowledged, so link-lost is still lit
        wr(10'h094, 16'h026B);
        cyc(3);
        chk(32'(pin), 32'h1);
        wr(10'h07C, 16'h4000);
        chk(32'(dig_rst), 32'h1);
        cyc(8);
        chk({30'h0, dig_rst, pin}, 32'h0);
        rd(10'h094, 32'h026B);
        rd(10'h07C, 32'h0);
        strap <= 1'b0;
        wr(10'h07C, 16'h8000);
        chk(32'(sw_rst), 32'h1);
        cyc(8);
        chk(32'(sw_rst), 32'h0);
        rd(10'h094, 32'h0200);
        rd(10'h09C, 32'h0);
        rd(10'h07C, 32'h0);
        end_sim();
    end
endmodule

bind prtc_top prtc_properties #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) u_props (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SOFT_RESET(SOFT_RESET), .DIGITAL_RESTART(DIGITAL_RESTART),
    .BIST_COUNT_CLEAR(BIST_COUNT_CLEAR), .TEST_CTRL(TEST_CTRL));
`default_nettype wire
